//--- rtl/jls_link_status_flags.sv
// Behaviour
// - resync flag clears when request is taken
// - request must persist four frame clocks
// - resync flag follows internal state, not pin
// - phase flag set only on real shift
// - writing one clears phase flag
// - sysref rising edge sets seen flag
// - writing one clears seen flag
// - clock loss clears seen and phase flags
// - bit two shows loop lock
// - bit one shows calibration complete
// - bit zero shows sample clock present
// - two's complement or offset binary sample coding
// - link flag after sync, alignment, data
// - resync source is pin or software level
module jls_link_status_flags
  import jls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // configuration port
  input wire logic [15:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  // resync source selection from the control register
  input wire logic resync_source_sel,
  input wire logic software_resync_level,
  // link side
  input wire logic syncb_pin_n,
  input wire logic sysref,
  input wire logic lfc_tick,
  input wire logic phase_adjust,
  input wire logic ilas_done,
  input wire logic data_valid,
  // converter side status
  input wire logic pll_locked,
  input wire logic cal_complete,
  input wire logic sample_clock_input,
  input wire logic sysref_detect_enable,
  // sample coding
  input wire logic offset_binary_sel,
  input wire logic [13:0] sample_in,
  output logic [13:0] sample_out,
  output logic internal_syncb_n,
  output logic link_established
);
  // ============================================================
  // state and flag storage
  jls_state_e state_q, state_d;
  logic sync_flag_q, sync_flag_d;       // 1 = no request
  logic phase_shift_flag_q, phase_shift_flag_d;
  logic seen_flag_q, seen_flag_d;
  logic link_q, link_d;
  logic sysref_prev_q;                  // for edge detect
  logic syncb_q;                        // selected resync level
  logic [7:0] rdata_q, rdata_d;
  logic [13:0] sample_q, sample_d;

  // ============================================================
  // decode
  logic syncb_sel;      // selected source, low = request
  logic req_valid;      // request persisted
  logic sysref_rise;
  logic status_hit;
  logic wr_hit;
  logic clr_phase;
  logic clr_seen;
  logic set_phase;
  logic set_seen;
  logic [7:0] status_byte;

  // ============================================================
  // shared flag rule
  // both write-one-to-clear flags follow the same priority: a missing
  // clock clears, then a hardware set, then a software clear; a set
  // must win over a clear so that no event is lost between reads
  function automatic logic jls_sticky_next(input logic clk_ok,
                                           input logic set_ev,
                                           input logic clr_ev,
                                           input logic cur);
    logic nxt;
    nxt = cur;
    if (!clk_ok) begin
      nxt = 1'b0;
    end else if (set_ev) begin
      nxt = 1'b1;
    end else if (clr_ev) begin
      nxt = 1'b0;
    end
    return nxt;
  endfunction

  // pin when select is 0, software level when select is 1
  assign syncb_sel = resync_source_sel ? software_resync_level
                                       : syncb_pin_n;
  assign status_hit = (cfg_addr == JLS_STATUS_ADDR);
  assign wr_hit = cfg_wr && status_hit;
  assign clr_phase = wr_hit && cfg_wdata[JLS_BIT_PHASE];
  assign clr_seen = wr_hit && cfg_wdata[JLS_BIT_SEEN];
  // detection is gated by the host enable; the host only enables it
  // after calibration, so no cal gate is duplicated here
  assign sysref_rise = sysref && !sysref_prev_q && sysref_detect_enable;
  assign set_seen = sysref_rise && sample_clock_input;
  assign set_phase = set_seen && phase_adjust;

  // persistence filter on the selected request level
  jls_sync_filter u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .syncb_n(syncb_q),
    .lfc_tick(lfc_tick),
    .req_valid(req_valid)
  );

  // ============================================================
  // synchronisation state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // idle until a persisted request arrives
      JLS_ST_IDLE: begin
        if (req_valid) begin
          state_d = JLS_ST_SYNC;
        end
      end
      // sync runs until the receiver releases the request
      JLS_ST_SYNC: begin
        if (syncb_q) begin
          state_d = JLS_ST_ILAS;
        end
      end
      // alignment sequence; a new request restarts sync
      JLS_ST_ILAS: begin
        if (req_valid) begin
          state_d = JLS_ST_SYNC;
        end else if (ilas_done) begin
          state_d = JLS_ST_DATA;
        end
      end
      // data; a new request restarts sync
      JLS_ST_DATA: begin
        if (req_valid) begin
          state_d = JLS_ST_SYNC;
        end
      end
    endcase
  end

  // flag is the state, not the pin, so it can lag the pin
  assign sync_flag_d = (state_d != JLS_ST_SYNC);
  assign link_d = (state_d == JLS_ST_DATA) && data_valid;

  // sticky flags: set wins over a software clear, clock loss wins over
  // both since no alignment can be trusted without a clock
  assign phase_shift_flag_d = jls_sticky_next(sample_clock_input,
                                              set_phase,
                                              clr_phase,
                                              phase_shift_flag_q);
  assign seen_flag_d = jls_sticky_next(sample_clock_input,
                                       set_seen,
                                       clr_seen,
                                       seen_flag_q);

  // read value assembled from live state
  assign status_byte = {1'b0,
                        link_q,
                        sync_flag_q,
                        phase_shift_flag_q,
                        seen_flag_q,
                        pll_locked,
                        cal_complete,
                        sample_clock_input};
  assign rdata_d = (cfg_rd && status_hit) ? status_byte :
                   cfg_rd ? JLS_RDATA_RST : rdata_q;

  // offset binary is two's complement with the top bit inverted
  assign sample_d = offset_binary_sel ?
                    {~sample_in[JLS_SMP_MSB], sample_in[JLS_SMP_MSB-1:0]} :
                    sample_in;

  // ============================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= JLS_ST_IDLE;
      sync_flag_q <= JLS_SYNC_RST;
      link_q <= JLS_FLAG_RST;
      syncb_q <= JLS_SYNC_RST;
    end else begin
      state_q <= state_d;
      sync_flag_q <= sync_flag_d;
      link_q <= link_d;
      syncb_q <= syncb_sel;
    end
  end

  // flag registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_shift_flag_q <= JLS_FLAG_RST;
      seen_flag_q <= JLS_FLAG_RST;
      sysref_prev_q <= 1'b0;
    end else begin
      phase_shift_flag_q <= phase_shift_flag_d;
      seen_flag_q <= seen_flag_d;
      sysref_prev_q <= sysref;
    end
  end

  // read data and sample registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= JLS_RDATA_RST;
      sample_q <= JLS_SMP_RST;
    end else begin
      rdata_q <= rdata_d;
      sample_q <= sample_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign sample_out = sample_q;
  assign internal_syncb_n = syncb_q;
  assign link_established = link_q;

  // ============================================================
  // checks
  // resync flag mirrors the state register, never the pin
  a_sync_flag_state: assert property (
    @(posedge clk_sys) disable iff (rst)
    sync_flag_q == (state_q != JLS_ST_SYNC))
    else $error("resync flag disagrees with state");
  // sync only starts from a request that the filter let through
  a_sync_needs_req: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(sync_flag_q) |-> $past(req_valid))
    else $error("sync started without persisted request");
  // phase flag only rises with an edge that really moved the clocks
  a_phase_only_shift: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(phase_shift_flag_q) |-> $past(phase_adjust) && $past(sysref_rise))
    else $error("phase flag set without shift");
  // write one clears the phase flag unless a set lands in the same cycle
  a_phase_w1c: assert property (
    @(posedge clk_sys) disable iff (rst)
    clr_phase && !set_phase |=> !phase_shift_flag_q)
    else $error("phase flag not cleared by write one");
  // writing zero to the phase bit leaves a set flag alone
  a_phase_keep_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_hit && !cfg_wdata[JLS_BIT_PHASE] && phase_shift_flag_q &&
    sample_clock_input |=> phase_shift_flag_q)
    else $error("writing zero changed phase flag");
  // a processed rising edge always leaves the seen flag up
  a_seen_on_edge: assert property (
    @(posedge clk_sys) disable iff (rst)
    set_seen |=> seen_flag_q)
    else $error("sysref edge did not set seen flag");
  // write one clears the seen flag unless a set lands in the same cycle
  a_seen_w1c: assert property (
    @(posedge clk_sys) disable iff (rst)
    clr_seen && !set_seen |=> !seen_flag_q)
    else $error("seen flag not cleared by write one");
  // writing zero to the seen bit leaves a set flag alone
  a_seen_keep_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_hit && !cfg_wdata[JLS_BIT_SEEN] && seen_flag_q && sample_clock_input
    |=> seen_flag_q)
    else $error("writing zero changed seen flag");
  // without a clock neither alignment flag may survive
  a_clock_loss_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    !sample_clock_input |=> !seen_flag_q && !phase_shift_flag_q)
    else $error("flags survive clock loss");
  // live status bits are captured as they stood at the read edge
  a_read_status: assert property (
    @(posedge clk_sys) disable iff (rst)
    cfg_rd && status_hit |=> cfg_rdata[JLS_BIT_LOCK] == $past(pll_locked) &&
    cfg_rdata[JLS_BIT_CAL] == $past(cal_complete) &&
    cfg_rdata[JLS_BIT_CLK] == $past(sample_clock_input))
    else $error("status read mismatch");
  // link bit only while data flows after alignment
  a_link_after_ilas: assert property (
    @(posedge clk_sys) disable iff (rst)
    link_established |-> state_q == JLS_ST_DATA)
    else $error("link up outside data state");
  // link bit never stands without valid data on the lane
  a_link_needs_valid: assert property (
    @(posedge clk_sys) disable iff (rst)
    link_established |-> $past(data_valid))
    else $error("link up without valid data");
  // offset binary differs from two's complement in the top bit only
  a_sample_code: assert property (
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> sample_out[JLS_SMP_MSB] ==
    ($past(sample_in[JLS_SMP_MSB]) ^ $past(offset_binary_sel)))
    else $error("sample coding wrong");
  // internal resync level follows the selected source one cycle later
  a_source_select: assert property (
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> internal_syncb_n == ($past(resync_source_sel) ?
    $past(software_resync_level) : $past(syncb_pin_n)))
    else $error("resync source wrong");
  // main scenarios worth seeing at least once
  c_link_up: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(link_established));
  c_resync: cover property (@(posedge clk_sys) disable iff (rst)
    state_q == JLS_ST_DATA ##1 state_q == JLS_ST_SYNC);
  c_phase_set: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(phase_shift_flag_q));
  c_seen_set: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(seen_flag_q));
  c_clock_loss: cover property (@(posedge clk_sys) disable iff (rst)
    seen_flag_q ##1 !sample_clock_input);
endmodule // jls_link_status_flags

//--- rtl/jls_pkg.sv
// ============================================================
// shared constants for the link status flag block
package jls_pkg;
  // register map
  localparam logic [15:0] JLS_STATUS_ADDR = 16'h006C; // link status flags
  // bit positions inside the status byte
  localparam int JLS_BIT_LINK = 6;  // link established
  localparam int JLS_BIT_SYNC = 5;  // resync request status
  localparam int JLS_BIT_PHASE = 4; // phase shift flag
  localparam int JLS_BIT_SEEN = 3;  // sysref seen
  localparam int JLS_BIT_LOCK = 2;  // loop lock
  localparam int JLS_BIT_CAL = 1;   // calibration done
  localparam int JLS_BIT_CLK = 0;   // sample clock present
  // reset values
  localparam logic JLS_SYNC_RST = 1'b1;  // idle: no request
  localparam logic JLS_FLAG_RST = 1'b0;  // sticky flags start clear
  localparam logic [7:0] JLS_RDATA_RST = 8'h00;
  // a request must stand this many local frame clocks
  localparam logic [2:0] JLS_SYNC_FRAMES = 3'h4;
  // sample width and offset binary midscale bit
  localparam int JLS_SMP_W = 14;
  localparam int JLS_SMP_MSB = 13;
  localparam logic [13:0] JLS_SMP_RST = 14'h0000;
  // synchronisation states
  typedef enum logic [2:0] {
    JLS_ST_IDLE,  // no request pending
    JLS_ST_SYNC,  // request accepted, code group sync running
    JLS_ST_ILAS,  // alignment sequence on the lane
    JLS_ST_DATA   // user data flowing
  } jls_state_e;
endpackage : jls_pkg

//--- rtl/jls_sync_filter.sv
// ============================================================
// request persistence filter: counts local frame ticks while
// the resync request stays low
module jls_sync_filter
  import jls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic syncb_n,   // internal resync level, low = request
  input wire logic lfc_tick,  // one pulse per local frame clock
  output logic req_valid      // request has persisted long enough
);
  logic [2:0] cnt_q; // frames seen with request held
  logic [2:0] cnt_d;
  logic req_valid_q;
  logic req_valid_d;

  // count saturates at the threshold; any release restarts it
  assign cnt_d = syncb_n ? 3'h0 :
                 (lfc_tick && cnt_q != JLS_SYNC_FRAMES) ?
                 3'(cnt_q + 3'h1) : cnt_q;
  assign req_valid_d = !syncb_n && (cnt_d == JLS_SYNC_FRAMES);
  assign req_valid = req_valid_q;

  // counter register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
      req_valid_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      req_valid_q <= req_valid_d;
    end
  end

  // ============================================================
  // checks
  a_req_needs_frames: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(req_valid) |-> cnt_q == JLS_SYNC_FRAMES)
    else $error("request accepted before four frames");
  a_req_drops_release: assert property (
    @(posedge clk_sys) disable iff (rst)
    syncb_n |=> !req_valid)
    else $error("request held after release");
endmodule // jls_sync_filter

//--- verification/jls_link_status_flags_tb_top.sv
// ==========================================================
// self-checking bench for the status flag block
module jls_link_status_flags_tb_top import jls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, cfg_wr, cfg_rd, resync_source_sel;
  logic software_resync_level, phase_adjust, ilas_done, data_valid;
  logic pll_locked, cal_complete, sample_clock_input;
  logic sysref_detect_enable, offset_binary_sel;
  logic lfc_tick, syncb_pin_n, sysref, internal_syncb_n;
  logic link_established;
  logic [15:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [13:0] sample_in, sample_out;
  int error_cnt, n_checks;
  // sample table: extremes, midscale and negative half scale of the code range
  logic [13:0] tv [4] = '{14'h2000, 14'h1FFF, 14'h0000, 14'h3000};
  jls_rx_model rx (.clk_sys(clk_sys), .lfc_tick(lfc_tick),
    .syncb_pin_n(syncb_pin_n), .sysref(sysref));
  jls_link_status_flags uut (.clk_sys(clk_sys), .rst(rst),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .resync_source_sel(resync_source_sel),
    .software_resync_level(software_resync_level),
    .syncb_pin_n(syncb_pin_n), .sysref(sysref), .lfc_tick(lfc_tick),
    .phase_adjust(phase_adjust), .ilas_done(ilas_done),
    .data_valid(data_valid), .pll_locked(pll_locked),
    .cal_complete(cal_complete), .sample_clock_input(sample_clock_input),
    .sysref_detect_enable(sysref_detect_enable),
    .offset_binary_sel(offset_binary_sel), .sample_in(sample_in),
    .sample_out(sample_out), .internal_syncb_n(internal_syncb_n),
    .link_established(link_established));
  // ========================================================
  // clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ========================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write strobe stands one cycle, changed on the falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask
  // read data lands one edge after the strobe is taken
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk_sys);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask
  task automatic rs(input logic [7:0] e);
    logic [7:0] d;
    rd(JLS_STATUS_ADDR, d);
    check({8'h00, d}, {8'h00, e});
  endtask
  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard: the sequence needs well under 1000 cycles
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  // ========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    rst = 1'b1;
    cfg_addr = JLS_STATUS_ADDR;
    cfg_wr = 1'b0;
    cfg_wdata = 8'h00;
    cfg_rd = 1'b0;
    resync_source_sel = 1'b0;
    software_resync_level = 1'b1;
    phase_adjust = 1'b0;
    ilas_done = 1'b0;
    data_valid = 1'b0;
    {pll_locked, cal_complete, sample_clock_input} = 3'h0;
    sysref_detect_enable = 1'b0;
    offset_binary_sel = 1'b0;
    sample_in = 14'h0000;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    check({15'h0, internal_syncb_n}, 16'h0001);
    rs(8'h20);
    // live status bits, one at a time
    for (int i = 0; i < 3; i++) begin
      {pll_locked, cal_complete, sample_clock_input} = 3'h4 >> i;
      @(negedge clk_sys);
      rs(8'h20 | (8'h04 >> i));
    end
    {pll_locked, cal_complete, sample_clock_input} = 3'h7;
    rs(8'h27);
    rd(16'h0000, d);
    check({8'h00, d}, 16'h0000);
    done_t("live_bits");
    // detection enabled only once calibration reads done
    sysref_detect_enable = 1'b1;
    rx.sysref_pulse;
    rs(8'h2F);
    wr(16'h006D, 8'h08);
    wr(JLS_STATUS_ADDR, 8'hE7);
    rs(8'h2F);
    wr(JLS_STATUS_ADDR, 8'h08);
    rs(8'h27);
    phase_adjust = 1'b1;
    rx.sysref_pulse;
    rs(8'h3F);
    wr(JLS_STATUS_ADDR, 8'h08);
    rs(8'h37);
    wr(JLS_STATUS_ADDR, 8'h10);
    rs(8'h27);
    rx.sysref_pulse;
    phase_adjust = 1'b0;
    sample_clock_input = 1'b0;
    @(negedge clk_sys);
    rs(8'h26);
    sample_clock_input = 1'b1;
    rs(8'h27);
    done_t("sysref");
    // short request is refused, flag tracks state not pin
    rx.sync_req(2, 1'b0);
    rs(8'h27);
    rx.sync_req(0, 1'b1);
    rx.wait_ticks(2);
    rs(8'h27);
    rx.sync_req(6, 1'b0);
    rs(8'h07);
    check({15'h0, internal_syncb_n}, 16'h0000);
    rx.sync_req(0, 1'b1);
    repeat (3) @(negedge clk_sys);
    rs(8'h27);
    ilas_done = 1'b1;
    @(negedge clk_sys);
    ilas_done = 1'b0;
    data_valid = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({15'h0, link_established}, 16'h0001);
    rs(8'h67);
    data_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    rs(8'h27);
    done_t("resync");
    // software level replaces the pin as request source
    resync_source_sel = 1'b1;
    software_resync_level = 1'b0;
    rx.wait_ticks(6);
    rs(8'h07);
    software_resync_level = 1'b1;
    repeat (3) @(negedge clk_sys);
    rs(8'h27);
    resync_source_sel = 1'b0;
    done_t("source_select");
    // sample coding in both formats
    for (int s = 0; s < 2; s++) begin
      offset_binary_sel = s[0];
      foreach (tv[k]) begin
        sample_in = tv[k];
        @(negedge clk_sys);
        check({2'h0, sample_out}, {2'h0, tv[k] ^ {s[0], 13'h0}});
      end
    end
    done_t("samples");
    final_report;
  end
endmodule // jls_link_status_flags_tb_top

//--- verification/jls_rx_model.sv
// ==========================================================
// far end: link receiver driving resync request and sysref
module jls_rx_model (
  input wire logic clk_sys,
  output logic lfc_tick,
  output logic syncb_pin_n,
  output logic sysref
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q; // frame divider
  initial begin
    lfc_tick = 1'b0;
    syncb_pin_n = 1'b1;
    sysref = 1'b0;
    div_q = 2'h0;
  end
  // one frame tick every fourth cycle, runs free like the device
  always @(negedge clk_sys) begin
    div_q <= div_q + 2'h1;
    lfc_tick <= (div_q == 2'h3);
  end
  // counts frame ticks, then returns on a falling edge
  task automatic wait_ticks(input int n);
    repeat (n) @(posedge clk_sys iff lfc_tick);
    @(negedge clk_sys);
  endtask
  // request held n ticks; short holds only when a test asks
  task automatic sync_req(input int n, input logic rel);
    syncb_pin_n = 1'b0;
    wait_ticks(n);
    if (rel) begin
      syncb_pin_n = 1'b1;
    end
  endtask
  // two-cycle high so the edge detector cannot miss it
  task automatic sysref_pulse;
    sysref = 1'b1;
    repeat (2) @(negedge clk_sys);
    sysref = 1'b0;
    @(negedge clk_sys);
  endtask
endmodule // jls_rx_model
